// ==== hdl/asrc_code.sv ====
// Result coder: turns a raw 11-bit sample into a 10-bit result code.
// Assumes sample is offset-free: unsigned for single, signed for diff.
`timescale 1ns/100ps
`default_nettype none
module asrc_code (
   // Sample in
   input wire logic diff,
   input wire logic [10:0] sample,
   // Code out
   output logic [9:0] code
);
   always_comb begin
      if (!diff) begin
         // Single-ended: clip to full unsigned range [R10]
         if (sample[10])
            code = asrc_pkg::CODE_MAX_SE;
         else
            code = sample[9:0];
      end else if (!sample[10] && sample[9]) begin
         code = asrc_pkg::CODE_POS_MAX; // [R11] [R13]
      end else if (sample[10] && !sample[9]) begin
         code = asrc_pkg::CODE_NEG_MAX; // [R13]
      end else begin
         // Two's complement, msb gives polarity [R11] [R12]
         code = {sample[10], sample[8:0]};
      end
   end
endmodule // asrc_code
`default_nettype wire

// ==== hdl/asrc_conv_timer.sv ====
// Conversion timer: counts a fixed conversion length after a start.
// Assumes start is a one-cycle pulse; starts while busy are dropped.
`timescale 1ns/100ps
`default_nettype none
module asrc_conv_timer #(
   parameter int CYCLES = asrc_pkg::CONV_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Control
   input wire logic start,
   input wire logic abort,
   // Status
   output logic busy,
   output logic done
);
   localparam int W = $clog2(CYCLES + 1);
   logic [W-1:0] count;
   logic [W-1:0] next_count;
   logic next_busy;
   logic next_done;
   // A one-cycle conversion would make done and start collide
   if (CYCLES < 2) begin : g_cycles_check
      $error("CYCLES must be at least 2");
   end
   always_comb begin
      next_count = count;
      next_busy = busy;
      next_done = 1'b0;
      if (abort) begin
         next_busy = 1'b0;
         next_count = '0;
      end else if (busy) begin
         if (count == W'(CYCLES - 1)) begin
            next_busy = 1'b0;
            next_done = 1'b1;
            next_count = '0;
         end else begin
            next_count = count + W'(1);
         end
      end else if (start) begin
         next_busy = 1'b1;
         next_count = '0;
      end
   end
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         count <= '0;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         count <= next_count;
         busy <= next_busy;
         done <= next_done;
      end
   end
endmodule // asrc_conv_timer
`default_nettype wire

// ==== hdl/asrc_top.sv ====
// Converter sleep and result control: registers, sleep start, wake.
// Assumes the analog core delivers one sample when sample.valid pulses,
// and a sleep controller reporting the halted core and its power mode.
//
// Summary of operation
// R01 - Bit 0 of the temperature sensor register switches the sensor on.
// R02 - Bits 7 to 1 of that register read zero and software keeps them 0.
// R03 - Software enables, idles, picks single mode and enables irq first.
// R04 - Idle or noise sleep with those settings starts a conversion.
// R05 - The conversion-complete request wakes the halted core.
// R06 - An earlier wake leaves the conversion running; its request follows.
// R07 - Other sleep modes never switch the converter off by themselves.
// R08 - Software toggles the converter before a post-sleep diff conversion.
// R09 - A completed conversion leaves its result in result_low/high.
// R10 - Single-ended results are unsigned 10-bit codes 0x000 to 0x3FF.
// R11 - Differential results are two's complement 0x200 to 0x1FF.
// R12 - The msb of a differential result, in result_high, is its sign.
// R13 - Differential codes saturate at 0x1FF and 0x200.
// R14 - Outside logic keeps converter pins still during a conversion.
`timescale 1ns/100ps
`default_nettype none
module asrc_top #(
   parameter int CONV_CYCLES = asrc_pkg::CONV_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Avalon-MM slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Sleep controller
   input wire logic cpu_halted,
   input wire asrc_pkg::asrc_power_e power_mode,
   output logic wake_request,
   // Analog core
   input wire asrc_pkg::asrc_sample_s sample_in,
   output logic temp_sensor_on,
   output logic converter_on,
   output logic conv_busy,
   // Interrupt
   output logic irq
);
   // ***************************************************************
   // Register state
   // ***************************************************************
   logic [7:0] ctrl;
   logic [7:0] next_ctrl;
   logic temp_on;
   logic next_temp_on;
   logic conv_done_flag;
   logic next_conv_done_flag;
   logic mask_done;
   logic next_mask_done;
   logic [9:0] result;
   logic [9:0] next_result;
   logic [31:0] next_readdata;
   logic next_waitrequest;
   logic next_irq;
   logic next_wake;
   logic pend_start;
   logic next_pend_start;
   logic sleep_armed;
   logic next_sleep_armed;
   // Timer and coder wires
   logic t_start;
   logic t_busy;
   logic t_done;
   logic [9:0] code;

   typedef enum logic [1:0] {
      SL_AWAKE,
      SL_WAIT,
      SL_CONV
   } asrc_sleep_e;
   asrc_sleep_e sl_state;
   asrc_sleep_e next_sl_state;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a == o);
   endfunction

   // ***************************************************************
   // Parameter checks
   // ***************************************************************
   // The early-wake assertion waits at most 300 cycles for completion
   if (CONV_CYCLES < 2 || CONV_CYCLES > 250) begin : g_param_check
      $error("CONV_CYCLES must lie between 2 and 250");
   end

   // ***************************************************************
   // Conversion timer and result coder
   // ***************************************************************
   asrc_conv_timer #(
      .CYCLES(CONV_CYCLES)
   ) u_timer (
      .clk(clk),
      .reset_n(reset_n),
      .start(t_start),
      .abort(!ctrl[asrc_pkg::CTRL_ON_BIT]),
      .busy(t_busy),
      .done(t_done)
   );
   asrc_code u_code (
      .diff(sample_in.diff),
      .sample(sample_in.sample),
      .code(code)
   );

   wire logic bus_wr = avs_write && avs_waitrequest;
   wire logic bus_rd = avs_read && avs_waitrequest;
   // Sleep start is allowed only in single mode, idle, with irq on [R03]
   wire logic sleep_ok = ctrl[asrc_pkg::CTRL_ON_BIT] &&
      ctrl[asrc_pkg::CTRL_SINGLE_BIT] && ctrl[asrc_pkg::CTRL_IE_BIT] &&
      !t_busy;
   wire logic quiet_mode = (power_mode == asrc_pkg::PWR_IDLE) ||
      (power_mode == asrc_pkg::PWR_NOISE);
   wire logic sw_start = bus_wr && hit(avs_address, asrc_pkg::OFF_CTRL) &&
      avs_byteenable[0] && avs_writedata[asrc_pkg::CTRL_START_BIT];

   // ***************************************************************
   // Sleep sequencer
   // ***************************************************************
   always_comb begin
      next_sl_state = sl_state;
      next_sleep_armed = 1'b0;
      case (sl_state)
         SL_AWAKE: begin
            if (cpu_halted && quiet_mode && sleep_ok) begin
               next_sl_state = SL_CONV;
               next_sleep_armed = 1'b1; // [R04]
            end
         end
         SL_CONV: begin
            // Early wake: conversion keeps going and core stays up [R06]
            if (!cpu_halted || t_done)
               next_sl_state = SL_WAIT;
         end
         SL_WAIT: begin
            // A new sleep needs the core to run again first
            if (!cpu_halted)
               next_sl_state = SL_AWAKE;
         end
         default: next_sl_state = SL_AWAKE;
      endcase
   end
   assign t_start = sleep_armed || pend_start;

   // ***************************************************************
   // Register file and bus
   // ***************************************************************
   always_comb begin
      next_ctrl = ctrl;
      next_temp_on = temp_on;
      next_mask_done = mask_done;
      next_conv_done_flag = conv_done_flag;
      next_result = result;
      next_readdata = avs_readdata;
      next_waitrequest = 1'b1;
      next_pend_start = 1'b0;
      if (bus_wr) begin
         next_waitrequest = 1'b0;
         if (avs_byteenable[0]) begin
            if (hit(avs_address, asrc_pkg::OFF_CTRL)) begin
               // Start bit is a strobe, never stored; other modes are
               // never turned off by hardware, only by software [R07]
               next_ctrl = avs_writedata[7:0] &
                  ~(8'h01 << asrc_pkg::CTRL_START_BIT);
            end else if (hit(avs_address, asrc_pkg::OFF_TEMP)) begin
               next_temp_on = avs_writedata[asrc_pkg::TEMP_ON_BIT]; // [R01]
            end else if (hit(avs_address, asrc_pkg::OFF_STAT)) begin
               if (avs_writedata[asrc_pkg::STAT_DONE_BIT])
                  next_conv_done_flag = 1'b0;
            end else if (hit(avs_address, asrc_pkg::OFF_MASK)) begin
               next_mask_done = avs_writedata[asrc_pkg::STAT_DONE_BIT];
            end
         end
      end else if (bus_rd) begin
         next_waitrequest = 1'b0;
         if (hit(avs_address, asrc_pkg::OFF_CTRL)) begin
            next_readdata = {24'h00_0000, ctrl};
         end else if (hit(avs_address, asrc_pkg::OFF_TEMP)) begin
            next_readdata = {31'h0000_0000, temp_on}; // [R02]
         end else if (hit(avs_address, asrc_pkg::OFF_STAT)) begin
            next_readdata = {30'h0000_0000, t_busy, conv_done_flag};
         end else if (hit(avs_address, asrc_pkg::OFF_MASK)) begin
            next_readdata = {31'h0000_0000, mask_done};
         end else if (hit(avs_address, asrc_pkg::OFF_RLOW)) begin
            next_readdata = {24'h00_0000, result[7:0]}; // [R09]
         end else if (hit(avs_address, asrc_pkg::OFF_RHIGH)) begin
            // Sign sits in bit 1 of result_high [R12]
            next_readdata = {30'h0000_0000, result[9:8]};
         end else begin
            next_readdata = asrc_pkg::RD_UNMAPPED;
         end
      end
      // The enabling write may carry the start strobe itself
      if (sw_start && !t_busy && next_ctrl[asrc_pkg::CTRL_ON_BIT])
         next_pend_start = 1'b1;
      if (t_done) begin
         // Completion wins over a same-cycle software clear [R09]
         next_conv_done_flag = 1'b1;
         next_result = code; // [R10] [R11]
      end
   end
   // Wake the core on completion while it sleeps [R05]
   assign next_wake = conv_done_flag && ctrl[asrc_pkg::CTRL_IE_BIT] &&
      cpu_halted;
   assign next_irq = conv_done_flag && mask_done;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ctrl <= asrc_pkg::CTRL_RESET;
         temp_on <= asrc_pkg::TEMP_RESET[0];
         mask_done <= 1'b0;
         conv_done_flag <= 1'b0;
         result <= 10'h000;
         avs_readdata <= 32'h0000_0000;
         avs_waitrequest <= 1'b1;
         pend_start <= 1'b0;
         sleep_armed <= 1'b0;
         sl_state <= SL_AWAKE;
         wake_request <= 1'b0;
         irq <= 1'b0;
         temp_sensor_on <= 1'b0;
         converter_on <= 1'b0;
         conv_busy <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         temp_on <= next_temp_on;
         mask_done <= next_mask_done;
         conv_done_flag <= next_conv_done_flag;
         result <= next_result;
         avs_readdata <= next_readdata;
         avs_waitrequest <= next_waitrequest;
         pend_start <= next_pend_start;
         sleep_armed <= next_sleep_armed;
         sl_state <= next_sl_state;
         wake_request <= next_wake;
         irq <= next_irq;
         temp_sensor_on <= next_temp_on; // [R01]
         converter_on <= next_ctrl[asrc_pkg::CTRL_ON_BIT]; // [R07]
         conv_busy <= t_busy;
      end
   end

   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sleep_start_a: assert property ( // [R04]
      (sl_state == SL_AWAKE && cpu_halted && quiet_mode && sleep_ok)
      |=> ##1 t_busy)
      else $error("sleep entry did not start a conversion");
   other_mode_a: assert property ( // [R07]
      (cpu_halted && power_mode == asrc_pkg::PWR_OTHER && !bus_wr &&
       ctrl[asrc_pkg::CTRL_ON_BIT]) |=> ctrl[asrc_pkg::CTRL_ON_BIT])
      else $error("converter switched off by sleep mode");
   done_flag_a: assert property ( // [R09]
      t_done |=> conv_done_flag && result == $past(code))
      else $error("result not held after completion");
   wake_a: assert property ( // [R05]
      (conv_done_flag && ctrl[asrc_pkg::CTRL_IE_BIT] && cpu_halted)
      |=> wake_request)
      else $error("no wake on completion");
   early_wake_a: assert property ( // [R06]
      (sl_state == SL_CONV && !cpu_halted && t_busy)
      |-> ##[1:300] (conv_done_flag || !ctrl[asrc_pkg::CTRL_ON_BIT]))
      else $error("early wake lost conversion request");
   temp_rsvd_a: assert property ( // [R02]
      ($past(bus_rd) && $past(avs_address) == asrc_pkg::OFF_TEMP)
      |-> avs_readdata[31:1] == 31'h0000_0000)
      else $error("reserved sensor bits not zero");
   temp_on_a: assert property ( // [R01]
      (bus_wr && avs_byteenable[0] &&
       avs_address == asrc_pkg::OFF_TEMP) |=>
      temp_sensor_on == $past(avs_writedata[0]))
      else $error("sensor enable not applied");
   single_code_a: assert property ( // [R10]
      (!sample_in.diff && sample_in.sample[10]) |->
      code == asrc_pkg::CODE_MAX_SE)
      else $error("single-ended code not clipped");
   diff_sat_a: assert property ( // [R13]
      (sample_in.diff && !sample_in.sample[10] && sample_in.sample[9])
      |-> code == asrc_pkg::CODE_POS_MAX)
      else $error("positive saturation wrong");
   diff_sign_a: assert property ( // [R12]
      (sample_in.diff && sample_in.sample[10]) |-> code[9])
      else $error("sign bit not set for negative");
   bus_answer_a: assert property (
      (avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
      else $error("bus answer late");

   sticky_done_a: assert property ( // [R09]
      (conv_done_flag && !(bus_wr && avs_byteenable[0] &&
       hit(avs_address, asrc_pkg::OFF_STAT) &&
       avs_writedata[asrc_pkg::STAT_DONE_BIT])) |=> conv_done_flag)
      else $error("completion flag lost without a clear");
   result_hold_a: assert property ( // [R09]
      !t_done |=> $stable(result))
      else $error("result changed without a completion");
   sleep_cause_a: assert property ( // [R04]
      sleep_armed |-> $past(cpu_halted && quiet_mode))
      else $error("sleep start without a quiet sleep mode");
   other_no_start_a: assert property ( // [R04]
      (sl_state == SL_AWAKE && power_mode == asrc_pkg::PWR_OTHER)
      |=> !sleep_armed)
      else $error("sleep start in a non-quiet sleep mode");
   answer_once_a: assert property (
      !avs_waitrequest |=> avs_waitrequest)
      else $error("bus answer held too long");
   irq_clear_a: assert property ( // [R05]
      !conv_done_flag |=> !irq)
      else $error("interrupt without a completion flag");
   sw_start_a: assert property (
      (sw_start && !t_busy && avs_writedata[asrc_pkg::CTRL_ON_BIT])
      |=> ##1 t_busy)
      else $error("software start did not start a conversion");
   off_abort_a: assert property (
      !ctrl[asrc_pkg::CTRL_ON_BIT] |=> !t_busy)
      else $error("conversion kept running while switched off");
   single_pass_a: assert property ( // [R10]
      (!sample_in.diff && !sample_in.sample[10]) |->
      code == sample_in.sample[9:0])
      else $error("single-ended code not passed through");
   neg_sat_a: assert property ( // [R13]
      (sample_in.diff && sample_in.sample[10] && !sample_in.sample[9])
      |-> code == asrc_pkg::CODE_NEG_MAX)
      else $error("negative saturation wrong");

   sleep_conv_c: cover property (sl_state == SL_CONV ##[1:50] t_done);
   early_wake_c: cover property (sl_state == SL_CONV && !cpu_halted);
   diff_neg_c: cover property (t_done && sample_in.diff && code[9]);
   irq_c: cover property (irq);
   wake_c: cover property (wake_request ##1 !cpu_halted);
endmodule // asrc_top
`default_nettype wire

// ==== pkg/asrc_pkg.sv ====
// Package of constants and carriers for the converter sleep/result control.
// Assumes a 32-bit Avalon-MM register bus with word-aligned registers.
`default_nettype none
package asrc_pkg;
   // ***************************************************************
   // Register byte offsets
   // ***************************************************************
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_TEMP = 8'h04;
   localparam logic [7:0] OFF_STAT = 8'h08;
   localparam logic [7:0] OFF_MASK = 8'h0C;
   localparam logic [7:0] OFF_RLOW = 8'h10;
   localparam logic [7:0] OFF_RHIGH = 8'h14;
   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int CTRL_ON_BIT = 0;
   localparam int CTRL_SINGLE_BIT = 1;
   localparam int CTRL_DIFF_BIT = 2;
   localparam int CTRL_START_BIT = 3;
   localparam int CTRL_IE_BIT = 4;
   localparam int TEMP_ON_BIT = 0;
   localparam int STAT_DONE_BIT = 0;
   localparam int SIGN_BIT = 1;
   // ***************************************************************
   // Reset values and codes
   // ***************************************************************
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] TEMP_RESET = 8'h00;
   localparam logic [9:0] CODE_MAX_SE = 10'h3FF;
   localparam logic [9:0] CODE_POS_MAX = 10'h1FF;
   localparam logic [9:0] CODE_NEG_MAX = 10'h200;
   localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
   // Conversion time in clock cycles
   localparam int CONV_CYCLES = 13;
   // ***************************************************************
   // Carriers
   // ***************************************************************
   typedef enum logic [1:0] {
      PWR_ACTIVE,
      PWR_IDLE,
      PWR_NOISE,
      PWR_OTHER
   } asrc_power_e;
   typedef struct packed {
      logic valid;
      logic diff;
      logic [10:0] sample;
   } asrc_sample_s;
endpackage
`default_nettype wire

// ==== tb/asrc_sleep_model.sv ====
// Behavioural model of the halting core and its sleep controller.
// Assumes one clock; the bench commands sleep with a one-cycle pulse.
`timescale 1ns/100ps
`default_nettype none
module asrc_sleep_model (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Bench commands
   input wire logic sleep_req,
   input wire asrc_pkg::asrc_power_e sleep_mode,
   input wire logic other_wake,
   // Block side
   input wire logic wake_request,
   output logic cpu_halted,
   output var asrc_pkg::asrc_power_e power_mode
);
   // Core stays active after any wake until the next sleep command
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cpu_halted <= 1'b0;
         power_mode <= asrc_pkg::PWR_ACTIVE;
      end else if (sleep_req) begin
         cpu_halted <= 1'b1;
         power_mode <= sleep_mode;
      end else if (cpu_halted && (wake_request || other_wake)) begin
         cpu_halted <= 1'b0;
         power_mode <= asrc_pkg::PWR_ACTIVE;
      end
   end
endmodule // asrc_sleep_model
`default_nettype wire

// ==== tb/asrc_tb_top.sv ====
// Self-checking bench for the converter sleep and result control block.
// Assumes the package and the sleep model are compiled before it.
`timescale 1ns/100ps
`default_nettype none
module asrc_tb_top;
   localparam int CONV = asrc_pkg::CONV_CYCLES;
   logic clk, reset_n, avs_read, avs_write, avs_waitrequest, cpu_halted;
   logic wake_request, temp_sensor_on, converter_on, conv_busy, irq;
   logic sleep_req, other_wake, b;
   logic [7:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0] avs_byteenable;
   asrc_pkg::asrc_power_e power_mode, sleep_mode;
   asrc_pkg::asrc_sample_s sample_in;
   int bad_count = 0;
   int n_compared = 0;
   int i;
   logic [11:0] td = 12'hFF0;
   int tv [12] = '{0, 1023, 1024, 341, 511, 600, 1, 0, -1, -511, -512, -600};

   asrc_top #(.CONV_CYCLES(CONV)) asrc_top_i (.clk(clk), .reset_n(reset_n),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .cpu_halted(cpu_halted), .power_mode(power_mode),
      .wake_request(wake_request), .sample_in(sample_in),
      .temp_sensor_on(temp_sensor_on), .converter_on(converter_on),
      .conv_busy(conv_busy), .irq(irq));
   asrc_sleep_model asrc_sleep_model_i (.clk(clk), .reset_n(reset_n),
      .sleep_req(sleep_req), .sleep_mode(sleep_mode),
      .other_wake(other_wake), .wake_request(wake_request),
      .cpu_halted(cpu_halted), .power_mode(power_mode));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ***************************************************************
   // Checks and bus cycles
   // ***************************************************************
   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One extra edge after release keeps back-to-back strobes apart
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] be,
                      output logic [31:0] q);
      int n;
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= w;
      avs_read <= !w;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (n >= 20) chk("waitrequest", 32'h0, 32'h1);
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be = 4'hF);
      logic [31:0] q;
      bus(1'b1, a, d, be, q);
   endtask

   task automatic rd_chk(input string nm, input logic [7:0] a,
                         input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, 4'hF, q);
      chk(nm, e, q);
   endtask

   function automatic logic [9:0] exp_code(input logic d, input int v);
      if (d) return (v > 511) ? 10'h1FF : (v < -512) ? 10'h200 : 10'(v);
      return (v > 1023) ? 10'h3FF : 10'(v);
   endfunction

   function automatic asrc_pkg::asrc_sample_s smp(input logic d, input int v);
      return asrc_pkg::asrc_sample_s'({1'b1, d, 11'(v)});
   endfunction

   task automatic fetch(input logic d, input int v, input logic irq_e);
      logic [31:0] q;
      logic [9:0] c;
      int n;
      c = exp_code(d, v);
      q = 32'h0;
      for (n = 0; n < 40 && q[0] !== 1'b1; n++)
         bus(1'b0, asrc_pkg::OFF_STAT, 32'h0, 4'hF, q);
      chk("conv_done_flag", 32'h1, {31'h0, q[0]});
      chk("irq", {31'h0, irq_e}, {31'h0, irq});
      rd_chk("result_low", asrc_pkg::OFF_RLOW, {24'h0, c[7:0]});
      bus(1'b0, asrc_pkg::OFF_RHIGH, 32'h0, 4'hF, q);
      chk("result_high", {30'h0, c[9:8]}, q);
      if (d) chk("sign", {31'h0, v < 0}, {31'h0, q[asrc_pkg::SIGN_BIT]});
      wr(asrc_pkg::OFF_STAT, 32'h1);
      rd_chk("status", asrc_pkg::OFF_STAT, 32'h0);
      chk("irq", 32'h0, {31'h0, irq});
   endtask

   // Sample is held still for the whole conversion
   task automatic convert(input logic d, input int v, input logic irq_e);
      sample_in <= smp(d, v);
      wr(asrc_pkg::OFF_CTRL, 32'h0000_0009);
      fetch(d, v, irq_e);
   endtask

   task automatic nap(input asrc_pkg::asrc_power_e m);
      sleep_req <= 1'b1;
      sleep_mode <= m;
      @(posedge clk);
      sleep_req <= 1'b0;
      @(posedge clk);
   endtask

   task automatic poke_wake();
      other_wake <= 1'b1;
      @(posedge clk);
      other_wake <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wait_wake(output logic seen);
      int n;
      seen = 1'b0;
      for (n = 0; n < CONV + 20 && cpu_halted !== 1'b0; n++) begin
         @(posedge clk);
         if (conv_busy === 1'b1) seen = 1'b1;
      end
   endtask

   // ***************************************************************
   // Main sequence
   // ***************************************************************
   initial begin
      reset_n = 1'b0;
      avs_address = 8'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      sleep_req = 1'b0;
      sleep_mode = asrc_pkg::PWR_ACTIVE;
      other_wake = 1'b0;
      sample_in = smp(1'b0, 0);
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      rd_chk("ctrl", asrc_pkg::OFF_CTRL, {24'h0, asrc_pkg::CTRL_RESET});
      rd_chk("temp", asrc_pkg::OFF_TEMP, {24'h0, asrc_pkg::TEMP_RESET});
      rd_chk("unmapped", 8'h40, asrc_pkg::RD_UNMAPPED);
      wr(asrc_pkg::OFF_TEMP, 32'h0000_0001);
      rd_chk("temp", asrc_pkg::OFF_TEMP, 32'h1);
      chk("temp_sensor_on", 32'h1, {31'h0, temp_sensor_on});
      wr(asrc_pkg::OFF_TEMP, 32'h0, 4'hE);
      chk("temp_sensor_on", 32'h1, {31'h0, temp_sensor_on});
      wr(asrc_pkg::OFF_TEMP, 32'h0);
      chk("temp_sensor_on", 32'h0, {31'h0, temp_sensor_on});
      wr(asrc_pkg::OFF_MASK, 32'h1);
      for (i = 0; i < 12; i++) convert(td[i], tv[i], 1'b1);
      for (i = 0; i < 2; i++) begin
         sample_in <= smp(1'b0, 300 + i);
         wr(asrc_pkg::OFF_CTRL, 32'h0000_0013);
         nap(i ? asrc_pkg::PWR_NOISE : asrc_pkg::PWR_IDLE);
         wait_wake(b);
         chk("conv_busy", 32'h1, {31'h0, b});
         chk("cpu_halted", 32'h0, {31'h0, cpu_halted});
         fetch(1'b0, 300 + i, 1'b1);
      end
      sample_in <= smp(1'b1, -5);
      wr(asrc_pkg::OFF_CTRL, 32'h0000_0013);
      nap(asrc_pkg::PWR_NOISE);
      repeat (3) @(posedge clk);
      poke_wake();
      chk("cpu_halted", 32'h0, {31'h0, cpu_halted});
      chk("conv_busy", 32'h1, {31'h0, conv_busy});
      fetch(1'b1, -5, 1'b1);
      nap(asrc_pkg::PWR_OTHER);
      repeat (CONV + 5) @(posedge clk);
      chk("converter_on", 32'h1, {31'h0, converter_on});
      chk("conv_busy", 32'h0, {31'h0, conv_busy});
      poke_wake();
      wr(asrc_pkg::OFF_CTRL, 32'h0);
      convert(1'b1, -300, 1'b1);
      wr(asrc_pkg::OFF_MASK, 32'h0);
      convert(1'b0, 77, 1'b0);
      final_report();
   end

   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      final_report();
   end
endmodule // asrc_tb_top
`default_nettype wire
